/* hdl/xid_defs.svh */
// constants for the extended instruction decoder
`ifndef XID_DEFS_SVH
`define XID_DEFS_SVH
`define XID_OPC_HI        8'hE8
`define XID_OPC_ADD       2'h0
`define XID_OPC_SUB       2'h1
`define XID_OPC_PUSH      2'h2
`define XID_OPC_MOVE      2'h3
`define XID_OPC_REGISTER_INDIRECT_CALL     16'h0014
`define XID_SECOND_PFX    4'hF
`define XID_FRAME_SEL     2'h3
`define XID_INDEX_LIMIT   8'h5F
`define XID_ADDR_W        12
`define XID_ZERO_BYTE     8'h00
`define XID_ZERO_ADDR     12'h000
`define XID_ONE_ADDR      12'h001
`define XID_ZERO_PC       21'h000000
`define XID_PC_STEP       21'h000002
// indirect addressing registers: the window of indirect data ports
`define XID_IND_BASE      12'hFDF
`define XID_IND_MASK      12'hFF8
`define XID_IND_MATCH     12'hFD8
`define XID_IND_HI_BASE   12'hFE7
`define XID_IND_HI_MATCH  12'hFE0
`define XID_IND_HI2_MATCH 12'hFE8
`define XID_IND_LOW_BITS  3'h7
`define XID_IND_SKIP      3'h5
`endif

/* hdl/xid_pkg.sv */
// types for the extended instruction decoder
package xid_pkg;
  typedef enum logic [2:0] {
    XID_IDLE,
    XID_RET_WAIT,
    XID_CALL_WAIT,
    XID_MOVE_SECOND
  } xid_state_t;
  typedef enum logic [2:0] {
    XID_OP_NONE,
    XID_OP_ADD,
    XID_OP_SUB,
    XID_OP_PUSH,
    XID_OP_MOVE,
    XID_OP_CALL
  } xid_op_t;
endpackage

/* hdl/xid_mem_if.sv */
// data memory request bundle between the decoder and its address unit
`timescale 1ns/1ps
interface xid_mem_if;
  logic [11:0] frame_ptr;
  logic [6:0]  offset;
  logic [11:0] addr;
  logic        is_indirect;
  modport requester (output frame_ptr, output offset, input addr, input is_indirect);
  modport unit      (input frame_ptr, input offset, output addr, output is_indirect);
endinterface

/* hdl/xid_addr_unit.sv */
// frame-relative address generator with indirect register detection
`timescale 1ns/1ps
`include "xid_defs.svh"
module xid_addr_unit (
  xid_mem_if.unit port_io
);
  // flag the indirect data ports (all three fsr windows)
  function automatic logic xid_is_ind(input logic [11:0] a);
    xid_is_ind = ((a & `XID_IND_MASK) == `XID_IND_MATCH && a[2:0] != `XID_IND_SKIP)
              || ((a & `XID_IND_MASK) == `XID_IND_HI_MATCH && a[2:0] != `XID_IND_SKIP)
              || ((a & `XID_IND_MASK) == `XID_IND_HI2_MATCH && a[2:0] != `XID_IND_SKIP);
  endfunction
  // wraps inside the 4096-byte data space
  assign port_io.addr        = port_io.frame_ptr + {5'h00, port_io.offset};
  assign port_io.is_indirect = xid_is_ind(port_io.addr);
endmodule

/* hdl/xid_decoder.sv */
// extended instruction decoder and executor
//
// Contract
// - extension on when unprogrammed; a programmed configuration bit enables or disables it.
// - access-bank operand 5Fh or below becomes offset from the frame pointer.
// - pointer add adds 6-bit literal to selected pointer, one cycle, no flags.
// - pointer subtract removes 6-bit literal from selected pointer, one cycle, no flags.
// - selector 11 targets the frame pointer and makes the returning variant.
// - returning variants load program counter from the return stack top.
// - returning variants take two cycles, second one idle.
// - indirect call pushes next address, loads low byte from working register, latches upper.
// - indirect call performs no shadow save or restore.
// - indexed-to-absolute move reads frame plus offset, writes 12-bit address, two cycles.
// - indexed-to-indexed move uses two frame offsets, chosen by one opcode bit.
// - move addresses reach the whole 4096-byte data space.
// - indirect source address yields 00h instead of an indirect access.
// - indirect destination of indexed move suppresses the write.
// - literal push writes at frame pointer then decrements it, one cycle.
`timescale 1ns/1ps
`include "xid_defs.svh"
module xid_decoder #(
  parameter logic EXT_DEFAULT = 1'b1
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  // configuration load
  input  wire logic        cfg_valid_in,
  input  wire logic        extension_enable_bit_in,
  // instruction stream
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] instr_in,
  // operand of a standard byte or bit instruction
  input  wire logic        access_bit_in,
  input  wire logic [7:0]  file_operand_in,
  // core registers read by the call and return forms
  input  wire logic [7:0]  working_register_in,
  input  wire logic [7:0]  counter_latch_high_in,
  input  wire logic [7:0]  counter_latch_upper_in,
  input  wire logic [20:0] pc_in,
  input  wire logic [20:0] return_stack_top_in,
  // data memory read return
  input  wire logic [7:0]  mem_rdata_in,
  // status and sequencing
  output logic             extension_active_out,
  output logic             indexed_operand_out,
  output logic [11:0]      indexed_addr_out,
  output logic             busy_out,
  // data memory requests
  output logic             mem_read_out,
  output logic [11:0]      mem_raddr_out,
  output logic             mem_write_out,
  output logic [11:0]      mem_waddr_out,
  output logic [7:0]       mem_wdata_out,
  // program counter and return stack
  output logic             pc_load_out,
  output logic [20:0]      pc_value_out,
  output logic             push_out,
  output logic [20:0]      push_value_out,
  output logic             pop_out,
  // file select pointers
  output logic [11:0]      ptr0_out,
  output logic [11:0]      ptr1_out,
  output logic [11:0]      ptr2_out
);
  // ==========================================================
  // state
  typedef struct packed {
    // sequencing
    xid_pkg::xid_state_t st;
    // enable flag
    logic                ext_on;
    // file select pointers
    logic [11:0]         ptr0;
    logic [11:0]         ptr1;
    logic [11:0]         ptr2;
    // move source capture
    logic [7:0]          src_data;
    logic                move_ss;
    // data memory write port
    logic                mem_write;
    logic [11:0]         mem_waddr;
    logic [7:0]          mem_wdata;
    // program counter and return stack
    logic                pc_load;
    logic [20:0]         pc_value;
    logic                push;
    logic [20:0]         push_value;
    logic                pop;
  } xid_regs_t;

  xid_regs_t r;
  xid_regs_t next_r;

  // one request bundle per address unit, all relative to the frame pointer
  xid_mem_if src_if ();
  xid_mem_if dst_if ();
  xid_mem_if opd_if ();

  // ==========================================================
  // address units
  // source of a move
  xid_addr_unit u_src (.port_io(src_if.unit));
  // destination of an indexed move
  xid_addr_unit u_dst (.port_io(dst_if.unit));
  // operand of a standard instruction in the access window
  xid_addr_unit u_opd (.port_io(opd_if.unit));

  // move source: offset in the first word
  assign src_if.frame_ptr = r.ptr2;
  assign src_if.offset    = instr_in[6:0];

  // move destination: offset in the second word
  assign dst_if.frame_ptr = r.ptr2;
  assign dst_if.offset    = instr_in[6:0];

  // standard operand offset
  assign opd_if.frame_ptr = r.ptr2;
  assign opd_if.offset    = file_operand_in[6:0];

  // ==========================================================
  // decode of the first word
  // top byte of the add form; its six high bits are shared by the literal and move forms
  localparam logic [7:0] EXT_HI = `XID_OPC_HI;

  function automatic xid_pkg::xid_op_t xid_decode(input logic [15:0] w);
    xid_decode = xid_pkg::XID_OP_NONE;
    // the call form is one fixed word
    if (w == `XID_OPC_REGISTER_INDIRECT_CALL) begin
      xid_decode = xid_pkg::XID_OP_CALL;
    // the other forms share six top bits; the next two pick the form
    end else if (w[15:10] == EXT_HI[7:2]) begin
      unique case (w[9:8])
        `XID_OPC_ADD:  xid_decode = xid_pkg::XID_OP_ADD;
        `XID_OPC_SUB:  xid_decode = xid_pkg::XID_OP_SUB;
        `XID_OPC_PUSH: xid_decode = xid_pkg::XID_OP_PUSH;
        `XID_OPC_MOVE: xid_decode = xid_pkg::XID_OP_MOVE;
      endcase
    end
  endfunction

  // ==========================================================
  // decoded operation and literal
  xid_pkg::xid_op_t op;
  logic [11:0]      lit;
  logic [2:0]       sel_hot;
  logic [11:0]      sel_ptr;
  logic [11:0]      adj_ptr;

  // extension words decode only while the enable flag is set
  assign op  = r.ext_on ? xid_decode(instr_in) : xid_pkg::XID_OP_NONE;
  assign lit = {6'h00, instr_in[5:0]};

  // ==========================================================
  // pointer selection
  // selector decode, shared by the pointer read and the pointer write
  function automatic logic [2:0] xid_ptr_hot(input logic [1:0] sel);
    unique case (sel)
      2'h0:    xid_ptr_hot = 3'h1;
      2'h1:    xid_ptr_hot = 3'h2;
      default: xid_ptr_hot = 3'h4;
    endcase
  endfunction

  assign sel_hot = xid_ptr_hot(instr_in[7:6]);

  // pick the pointer the selector names
  always_comb begin
    sel_ptr = r.ptr2;
    if (sel_hot[0]) begin
      sel_ptr = r.ptr0;
    end else if (sel_hot[1]) begin
      sel_ptr = r.ptr1;
    end
    adj_ptr = (op == xid_pkg::XID_OP_SUB) ? sel_ptr - lit : sel_ptr + lit;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_r           = r;
    // pulses last one cycle unless set again below
    next_r.mem_write = 1'b0;
    next_r.pc_load   = 1'b0;
    next_r.push      = 1'b0;
    next_r.pop       = 1'b0;
    // a programming write replaces the enable flag
    if (cfg_valid_in) begin
      next_r.ext_on = extension_enable_bit_in;
    end
    unique case (r.st)
      xid_pkg::XID_IDLE: begin
        // first word of an instruction
        if (instr_valid_in) begin
          unique case (op)
            // pointer adjust; the selector 11 frame pointer form also returns
            xid_pkg::XID_OP_ADD, xid_pkg::XID_OP_SUB: begin
              if (sel_hot[0]) begin
                next_r.ptr0 = adj_ptr;
              end else if (sel_hot[1]) begin
                next_r.ptr1 = adj_ptr;
              end else begin
                next_r.ptr2 = adj_ptr;
              end
              // jump to the return stack top and drop that entry
              if (instr_in[7:6] == `XID_FRAME_SEL) begin
                next_r.pc_load  = 1'b1;
                next_r.pc_value = return_stack_top_in;
                next_r.pop      = 1'b1;
                next_r.st       = xid_pkg::XID_RET_WAIT;
              end
            end
            // literal stored at the frame pointer
            xid_pkg::XID_OP_PUSH: begin
              next_r.mem_write = 1'b1;
              next_r.mem_waddr = r.ptr2;
              next_r.mem_wdata = instr_in[7:0];
              // post-decrement, so the next push lands below
              next_r.ptr2      = r.ptr2 - `XID_ONE_ADDR;
            end
            xid_pkg::XID_OP_CALL: begin
              // no shadow copies of working, status or bank registers
              next_r.push       = 1'b1;
              next_r.push_value = pc_in + `XID_PC_STEP;
              // target from the latched upper bytes and the working register
              next_r.pc_load    = 1'b1;
              next_r.pc_value   = {counter_latch_upper_in[4:0], counter_latch_high_in, working_register_in};
              next_r.st         = xid_pkg::XID_CALL_WAIT;
            end
            // source read now, destination with the second word
            xid_pkg::XID_OP_MOVE: begin
              next_r.src_data = src_if.is_indirect ? `XID_ZERO_BYTE : mem_rdata_in;
              next_r.move_ss  = instr_in[7];
              next_r.st       = xid_pkg::XID_MOVE_SECOND;
            end
            // standard instructions are not handled here
            default: begin
            end
          endcase
        end
      end
      // second cycle of a return or call is idle
      xid_pkg::XID_RET_WAIT, xid_pkg::XID_CALL_WAIT: begin
        next_r.st = xid_pkg::XID_IDLE;
      end
      xid_pkg::XID_MOVE_SECOND: begin
        // the second word is consumed here, never decoded as its own instruction
        if (instr_valid_in && instr_in[15:12] == `XID_SECOND_PFX) begin
          next_r.st        = xid_pkg::XID_IDLE;
          next_r.mem_wdata = r.src_data;
          // indexed destination, else the 12-bit address of the second word
          if (r.move_ss) begin
            next_r.mem_waddr = dst_if.addr;
            next_r.mem_write = !dst_if.is_indirect;
          end else begin
            next_r.mem_waddr = instr_in[11:0];
            next_r.mem_write = 1'b1;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // register the state
  always_ff @(posedge clock_in or negedge rstn_in) begin
    // reset leaves the extension on, as on an unprogrammed part
    if (!rstn_in) begin
      r            <= '0;
      r.st         <= xid_pkg::XID_IDLE;
      r.ext_on     <= EXT_DEFAULT;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  // status and sequencing
  assign extension_active_out = r.ext_on;
  assign indexed_operand_out  = r.ext_on && !access_bit_in && file_operand_in <= `XID_INDEX_LIMIT;
  assign indexed_addr_out     = opd_if.addr;
  assign busy_out             = r.st != xid_pkg::XID_IDLE;

  // data memory: the source read is combinational, the write registered
  assign mem_read_out         = r.st == xid_pkg::XID_IDLE && op == xid_pkg::XID_OP_MOVE && instr_valid_in
                                && !src_if.is_indirect;
  assign mem_raddr_out        = src_if.addr;
  assign mem_write_out        = r.mem_write;
  assign mem_waddr_out        = r.mem_waddr;
  assign mem_wdata_out        = r.mem_wdata;

  // program counter and return stack
  assign pc_load_out          = r.pc_load;
  assign pc_value_out         = r.pc_value;
  assign push_out             = r.push;
  assign push_value_out       = r.push_value;
  assign pop_out              = r.pop;

  // file select pointers
  assign ptr0_out             = r.ptr0;
  assign ptr1_out             = r.ptr1;
  assign ptr2_out             = r.ptr2;
endmodule

/* verif/xid_decoder_checker.sv */
// port-level assertions for the extended instruction decoder
`timescale 1ns/1ps
module xid_decoder_checker (
  input wire logic        clock_in,
  input wire logic        rstn_in,
  input wire logic        cfg_valid_in,
  input wire logic        extension_enable_bit_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0]  working_register_in,
  input wire logic [7:0]  counter_latch_high_in,
  input wire logic [7:0]  counter_latch_upper_in,
  input wire logic [20:0] pc_in,
  input wire logic [20:0] return_stack_top_in,
  input wire logic        extension_active_out,
  input wire logic        busy_out,
  input wire logic        mem_read_out,
  input wire logic [11:0] mem_raddr_out,
  input wire logic        mem_write_out,
  input wire logic [11:0] mem_waddr_out,
  input wire logic [7:0]  mem_wdata_out,
  input wire logic        pc_load_out,
  input wire logic [20:0] pc_value_out,
  input wire logic        push_out,
  input wire logic [20:0] push_value_out,
  input wire logic        pop_out,
  input wire logic [11:0] ptr0_out,
  input wire logic [11:0] ptr1_out,
  input wire logic [11:0] ptr2_out
);
  // ==========================================
  // first word accepted in this cycle
  logic take;
  assign take = instr_valid_in && !busy_out && extension_active_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // returning variants: jump with pop, then one idle cycle
  sequence s_ret_jump;
    pc_load_out && pop_out && busy_out && pc_value_out == $past(return_stack_top_in);
  endsequence
  sequence s_ret_idle;
    !pc_load_out && !busy_out;
  endsequence
  AST_ADD_PTR0: assert property (
    take && instr_in[15:6] == 10'h3A0 |=> ptr0_out == $past(ptr0_out) + {6'h00, $past(instr_in[5:0])})
    else $error("pointer add wrong");
  AST_SUB_PTR1: assert property (
    take && instr_in[15:6] == 10'h3A5 |=> ptr1_out == $past(ptr1_out) - {6'h00, $past(instr_in[5:0])})
    else $error("pointer subtract wrong");
  AST_FRAME_RET: assert property (
    take && instr_in[15:9] == 7'h74 && instr_in[7:6] == 2'h3 |=> s_ret_jump ##1 s_ret_idle)
    else $error("returning variant wrong");
  AST_CALL: assert property (
    take && instr_in == 16'h0014 |=> push_out && pc_load_out && push_value_out == $past(pc_in) + 21'h000002
    && pc_value_out == {$past(counter_latch_upper_in[4:0]), $past(counter_latch_high_in), $past(working_register_in)})
    else $error("indirect call wrong");
  AST_PUSH: assert property (
    take && instr_in[15:8] == 8'hEA |=> mem_write_out && mem_waddr_out == $past(ptr2_out)
    && mem_wdata_out == $past(instr_in[7:0]) && ptr2_out == $past(ptr2_out) - 12'h001)
    else $error("literal push wrong");
  AST_MOVE_READ: assert property (
    take && instr_in[15:8] == 8'hEB && mem_read_out |-> mem_raddr_out == ptr2_out + {5'h00, instr_in[6:0]})
    else $error("move source address wrong");
  AST_MOVE_HOLD: assert property (
    take && instr_in[15:8] == 8'hEB |=> busy_out && !mem_write_out)
    else $error("move first word not held");
  AST_CFG: assert property (
    cfg_valid_in |=> extension_active_out == $past(extension_enable_bit_in))
    else $error("enable flag not loaded");
endmodule

bind xid_decoder xid_decoder_checker chk (.*);

/* verif/testbench.sv */
// self-checking bench for the extended instruction decoder
`timescale 1ns/1ps
module testbench;
  logic        clock_in = 1'b0, rstn_in = 1'b0, cfg_valid_in = 1'b0, extension_enable_bit_in = 1'b1;
  logic        instr_valid_in = 1'b0, access_bit_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic [7:0]  file_operand_in = 8'h5F, working_register_in = 8'h06, counter_latch_high_in = 8'h10;
  logic [7:0]  counter_latch_upper_in = 8'h01, mem_rdata_in = 8'h33, mem_wdata_out;
  logic [20:0] pc_in = 21'h000100, return_stack_top_in = 21'h012344, pc_value_out, push_value_out;
  logic        extension_active_out, indexed_operand_out, busy_out, mem_read_out, mem_write_out;
  logic        pc_load_out, push_out, pop_out;
  logic [11:0] indexed_addr_out, mem_raddr_out, mem_waddr_out, ptr0_out, ptr1_out, ptr2_out;
  logic [11:0] p2 = 12'h005;
  int          err_count = 0, n_compared = 0, cycles = 0;

  xid_decoder dut (.*);

  // ==========================================
  // clock and hang guard
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_count++;
      summarize();
    end
  end

  // ==========================================
  // shared helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // a word offered at the falling edge, outputs settled 1 ns later
  task automatic op(input logic [15:0] w);
    @(negedge clock_in);
    instr_in = w;
    instr_valid_in = 1'b1;
    #1;
  endtask
  task automatic idle();
    @(negedge clock_in);
    instr_valid_in = 1'b0;
    #1;
  endtask
  task automatic set_cfg(input logic en);
    @(negedge clock_in);
    cfg_valid_in = 1'b1;
    extension_enable_bit_in = en;
    @(negedge clock_in);
    cfg_valid_in = 1'b0;
    #1;
    check(extension_active_out, en, "enable flag");
  endtask

  // ==========================================
  // scenarios
  task automatic t_ptr();
    check({indexed_operand_out, indexed_addr_out}, 13'h105F, "indexed 5F");
    file_operand_in = 8'h60;
    #1;
    check(indexed_operand_out, 1'b0, "absolute 60");
    op(16'hE83F);
    op(16'hE941);
    check(ptr0_out, 12'h03F, "add 63");
    op(16'hE885);
    check(ptr1_out, 12'hFFF, "sub wrap");
    idle();
    check(ptr2_out, p2, "frame add");
  endtask
  task automatic t_ret();
    for (int i = 0; i < 2; i++) begin
      op(i ? 16'hE9C3 : 16'hE8C3);
      op(16'hEA55);
      p2 = i ? p2 - 12'h003 : p2 + 12'h003;
      check({pc_load_out, pop_out, busy_out, ptr2_out}, {3'h7, p2}, "frame return");
      check(pc_value_out, return_stack_top_in, "return target");
      idle();
      check({pc_load_out, busy_out, mem_write_out}, 3'h0, "idle cycle");
    end
  endtask
  task automatic t_call_push();
    op(16'h0014);
    idle();
    check({push_out, pc_load_out, busy_out, mem_write_out}, 4'hE, "call");
    check({push_value_out, pc_value_out}, {21'h000102, 21'h011006}, "call values");
    op(16'hEA08);
    idle();
    check({mem_write_out, mem_waddr_out, mem_wdata_out, ptr2_out}, {1'b1, p2, 8'h08, p2 - 12'h001}, "push");
    p2 = p2 - 12'h001;
  endtask
  task automatic t_moves();
    op(16'hEB05);
    check({mem_read_out, mem_raddr_out}, {1'b1, p2 + 12'h005}, "source read");
    op(16'h1234);
    mem_rdata_in = 8'h55;
    op(16'hFFFC);
    check({busy_out, mem_write_out}, 2'h2, "plain word ignored");
    idle();
    check({mem_write_out, mem_waddr_out, mem_wdata_out}, {1'b1, 12'hFFC, 8'h33}, "absolute move");
    op(16'hEB82);
    op(16'hF003);
    idle();
    check({mem_write_out, mem_waddr_out, mem_wdata_out}, {1'b1, p2 + 12'h003, 8'h55}, "indexed move");
  endtask
  task automatic t_indirect();
    op(16'hE984);
    op(16'hEA00);
    op(16'hE990);
    op(16'hEB80);
    check({mem_read_out, ptr2_out}, 13'h0FEF, "no indirect read");
    op(16'hF001);
    idle();
    check({mem_write_out, mem_waddr_out, mem_wdata_out}, {1'b1, 12'hFF0, 8'h00}, "zero source");
    op(16'hEB91);
    op(16'hF000);
    idle();
    check(mem_write_out, 1'b0, "indirect target");
  endtask
  task automatic t_cfg();
    set_cfg(1'b0);
    file_operand_in = 8'h05;
    op(16'hEA08);
    idle();
    check({mem_write_out, ptr2_out, indexed_operand_out}, {1'b0, 12'hFEF, 1'b0}, "disabled");
    set_cfg(1'b1);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    rstn_in = 1'b1;
    #1;
    check(extension_active_out, 1'b1, "default on");
    t_ptr();
    t_ret();
    t_call_push();
    t_moves();
    t_indirect();
    t_cfg();
    summarize();
  end
endmodule
